/* sowc_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sowc_buf2 #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_q [2]; // storage, addressed by pointer
	logic wr_q; // write pointer
	logic rd_q; // read pointer
	logic [1:0] cnt_q; // entries held
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// flags decode straight from the count flop
	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];

	// data store; no reset needed since valid guards it
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count; both ends may move in one cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule

/* sowc_mem_model.sv */
// memory side model: takes requests, stalls on demand, keeps what it took
`timescale 1ns/1ps
module sowc_mem_model import sowc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic mem_valid,
	input wire sowc_mem_s mem_req,
	output logic mem_ready
);
	sowc_mem_s taken[$]; // requests in the order they were accepted
	logic [1:0] tick = 2'h0; // paces the slow mode
	// ready moves at the falling edge, clear of the sampling edge
	always @(negedge ref_clk) begin
		tick <= tick + 2'h1;
		mem_ready <= !slow || tick == 2'h3;
	end
	// acceptance counts as completion to memory
	always @(posedge ref_clk) begin
		if (rst_n && mem_valid && mem_ready)
			taken.push_back(mem_req);
	end
endmodule

/* sowc_pkg.sv */
// shared constants, types and carriers for the store ordering and write combining unit
// Functional notes
// - cacheable load may pass store; full_fence blocks
// - combining load may pass load; load_fence orders
// - no store ever passes an earlier load
// - drain everything before io, atomic, serializing access
// - uncached access never passes any earlier access
// - ordinary stores reach memory in program order
// - combining store never passes conflicting combining store
// - loads never pass an earlier uncached store
// - cacheable store vs combining store; store_fence orders
// - io and atomic complete before later accesses
// - serializing accesses complete before next fetch
// - lookups check write buffer; retire in order
// - store_fence and full_fence drain older writes first
// - atomic and port writes never held buffered
// - interrupt or exception drains write buffer first
// - combining flush goes to main memory only
// - first combining write assigns aligned buffer range
// - writes in range merge; later bytes overwrite
// - fences, io, atomic, swap, traps flush combining; the code's load_fence flushes nothing
// - non-combining access in range flushes that buffer
// - combining write out of range flushes, reassigns; the code uses a free buffer first, flushing victim_q only if none is free
// - uncached access drains and empties all buffers
package sowc_pkg;
	localparam int SOWC_AW = 32; // physical address width
	localparam int SOWC_DW = 64; // one data word
	localparam int SOWC_BW = SOWC_DW / 8; // byte lanes in a word
	localparam int SOWC_WORD_OFF = 3; // byte offset bits inside a word
	localparam int SOWC_WB_DEPTH = 4; // write buffer entries
	localparam int SOWC_WCB_NUM = 2; // combining buffers
	localparam int SOWC_WCB_WORDS = 4; // words per combining buffer
	localparam logic SOWC_READY_RST = 1'b1; // op slot is free after reset

	// operation kinds arriving from the pipeline
	typedef enum logic [3:0] {
		OP_LOAD,
		OP_STORE,
		OP_LOAD_FENCE,
		OP_STORE_FENCE,
		OP_FULL_FENCE,
		OP_IO_READ,
		OP_IO_WRITE,
		OP_ATOMIC,
		OP_SWAP,
		OP_SERIALIZE,
		OP_INTERRUPT
	} sowc_op_e;

	// memory type of the accessed region
	typedef enum logic [2:0] {
		uncached_type,
		combining_type,
		snooped_combining_type,
		write_protect_type,
		writethrough_type,
		writeback_type
	} sowc_mtype_e;

	// commands sent to the cache and memory side
	typedef enum logic [2:0] {
		MEM_READ,
		MEM_WRITE,
		MEM_IO_READ,
		MEM_IO_WRITE,
		MEM_LOCKED_RMW
	} sowc_cmd_e;

	// one operation from the pipeline
	typedef struct packed {
		sowc_op_e kind;
		sowc_mtype_e mtype;
		logic bypass_store_marker;
		logic [SOWC_AW-1:0] addr;
		logic [SOWC_DW-1:0] data;
		logic [SOWC_BW-1:0] be;
	} sowc_op_s;

	// one request to the memory side
	typedef struct packed {
		sowc_cmd_e cmd;
		logic memory_only; // must bypass the caches
		logic [SOWC_AW-1:0] addr;
		logic [SOWC_DW-1:0] data;
		logic [SOWC_BW-1:0] be;
	} sowc_mem_s;
endpackage

/* sowc_unit.sv */
// store ordering, write buffer and write combining unit
`timescale 1ns/1ps
module sowc_unit import sowc_pkg::*; #(
	parameter int WB_DEPTH = SOWC_WB_DEPTH,
	parameter int WCB_NUM = SOWC_WCB_NUM,
	parameter int WCB_WORDS = SOWC_WCB_WORDS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	output logic op_ready,
	input wire sowc_op_s op_in,
	output logic mem_valid,
	input wire logic mem_ready,
	output sowc_mem_s mem_req,
	output logic fetch_release,
	output logic idle
);
	localparam int LOFF = $clog2(WCB_WORDS) + SOWC_WORD_OFF; // line offset bits
	localparam int LAW = SOWC_AW - LOFF; // line address width
	localparam int WCW = $clog2(WCB_WORDS); // word index width
	localparam int PW = $clog2(WB_DEPTH); // write buffer pointer width
	localparam int CW = $clog2(WB_DEPTH + 1); // write buffer count width
	localparam int NIW = $clog2(WCB_NUM); // combining buffer index width
	typedef logic [SOWC_AW-SOWC_WORD_OFF-1:0] sowc_word_t;

	// word address used for conflict checks
	function automatic sowc_word_t word_of(input logic [SOWC_AW-1:0] a);
		return a[SOWC_AW-1:SOWC_WORD_OFF];
	endfunction

	// pointer step with wrap for any depth
	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		return (p == PW'(WB_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	logic ready_q; // op slot free
	logic op_v_q; // op held and not yet retired
	sowc_op_s op_q; // held op
	logic post_q; // io, atomic or uncached access issued, waiting to reach memory
	logic fetch_q; // fetch may proceed after serializing event
	logic idle_q; // everything drained
	sowc_mem_s wb_mem_q [WB_DEPTH]; // program order write buffer
	logic [PW-1:0] wb_head_q;
	logic [PW-1:0] wb_tail_q;
	logic [CW-1:0] wb_cnt_q;
	logic [WCB_NUM-1:0] wcb_v_q; // buffer holds an active range
	logic [LAW-1:0] wcb_line_q [WCB_NUM]; // active range per buffer
	logic [WCB_WORDS-1:0][SOWC_DW-1:0] wcb_data_q [WCB_NUM];
	logic [WCB_WORDS-1:0][SOWC_BW-1:0] wcb_mask_q [WCB_NUM]; // per-byte valid
	logic fl_act_q; // flush in progress
	logic [NIW-1:0] fl_idx_q; // buffer being flushed
	logic [WCW-1:0] fl_beat_q; // word being sent
	logic [NIW-1:0] victim_q; // next buffer to evict

	logic buf_ready; // skid buffer accepts
	logic push_v;
	sowc_mem_s push_d;
	logic is_comb; // combining or bypass-marked store
	logic [WCB_NUM-1:0] line_hit;
	logic any_hit;
	logic [NIW-1:0] hit_idx;
	logic any_free;
	logic [NIW-1:0] free_idx;
	logic wb_conf; // load hits a buffered store
	logic [WCB_NUM-1:0] flush_req; // buffers to flush before op proceeds
	logic need_wb; // write buffer must be empty first
	logic need_quiet; // everything must be in memory first
	logic need_port; // op sends a request itself
	logic need_space; // op enters the write buffer
	logic go; // ordering lets the op proceed
	logic op_done; // op retires this cycle
	logic wb_pop;
	logic fl_adv; // flush advances one word
	logic all_quiet;
	logic [LAW-1:0] op_line;
	logic [WCW-1:0] op_word;
	sowc_mem_s op_mem; // request built from the held op

	assign op_line = op_q.addr[SOWC_AW-1:LOFF];
	assign op_word = op_q.addr[LOFF-1:SOWC_WORD_OFF];
	assign is_comb = (op_q.kind == OP_STORE) && (op_q.bypass_store_marker ||
		op_q.mtype == combining_type || op_q.mtype == snooped_combining_type);
	assign all_quiet = (wb_cnt_q == '0) && !(|wcb_v_q) && !fl_act_q && !mem_valid;

	// range lookup and free buffer search over all combining buffers
	always_comb begin
		any_hit = 1'b0;
		hit_idx = '0;
		any_free = 1'b0;
		free_idx = '0;
		for (int i = 0; i < WCB_NUM; i++) begin
			line_hit[i] = wcb_v_q[i] && (wcb_line_q[i] == op_line);
			if (line_hit[i] && !any_hit) begin
				any_hit = 1'b1;
				hit_idx = NIW'(i);
			end
			if (!wcb_v_q[i] && !any_free) begin
				any_free = 1'b1;
				free_idx = NIW'(i);
			end
		end
	end

	// every load looks up the pending stores in the write buffer
	always_comb begin
		wb_conf = 1'b0;
		for (int i = 0; i < WB_DEPTH; i++) begin
			if ((PW'(i) - wb_head_q) < PW'(wb_cnt_q) || wb_cnt_q == CW'(WB_DEPTH)) begin
				if (word_of(wb_mem_q[i].addr) == word_of(op_q.addr)) begin
					wb_conf = 1'b1;
				end
			end
		end
	end

	// ordering decision for the held op
	always_comb begin
		flush_req = '0;
		need_wb = 1'b0;
		need_quiet = 1'b0;
		need_port = 1'b0;
		need_space = 1'b0;
		op_mem = '{cmd: MEM_READ, memory_only: 1'b0, addr: op_q.addr,
			data: op_q.data, be: op_q.be};
		unique case (op_q.kind)
			OP_LOAD: begin
				need_port = 1'b1;
				if (op_q.mtype == uncached_type) begin
					// nothing older may be outstanding
					flush_req = wcb_v_q;
					need_wb = 1'b1;
					need_quiet = 1'b1;
					op_mem.memory_only = 1'b1;
				end else begin
					// non-conflicting loads overtake buffered stores
					flush_req = line_hit;
					need_wb = wb_conf;
				end
			end
			OP_STORE: begin
				op_mem.cmd = MEM_WRITE;
				if (is_comb) begin
					// merge, assign, or evict when no buffer is free
					if (!any_hit && !any_free) begin
						flush_req[victim_q] = 1'b1;
					end
				end else if (op_q.mtype == uncached_type) begin
					flush_req = wcb_v_q;
					need_wb = 1'b1;
					need_quiet = 1'b1;
					need_port = 1'b1;
					op_mem.memory_only = 1'b1;
				end else begin
					flush_req = line_hit;
					need_space = 1'b1; // ordinary stores queue in order
				end
			end
			OP_LOAD_FENCE: begin
				// loads already issue in program order
			end
			OP_STORE_FENCE, OP_FULL_FENCE: begin
				// older writes and combined data drain before younger ops
				flush_req = wcb_v_q;
				need_wb = 1'b1;
			end
			OP_IO_READ, OP_IO_WRITE, OP_ATOMIC, OP_SWAP: begin
				// fully drained first, and never buffered
				flush_req = wcb_v_q;
				need_wb = 1'b1;
				need_quiet = 1'b1;
				need_port = 1'b1;
				op_mem.cmd = (op_q.kind == OP_IO_READ) ? MEM_IO_READ :
					(op_q.kind == OP_IO_WRITE) ? MEM_IO_WRITE : MEM_LOCKED_RMW;
				op_mem.memory_only = (op_q.kind == OP_IO_READ || op_q.kind == OP_IO_WRITE);
			end
			OP_SERIALIZE, OP_INTERRUPT: begin
				// drain before the next fetch or handler fetch
				flush_req = wcb_v_q;
				need_wb = 1'b1;
				need_quiet = 1'b1;
			end
			default: begin
				// illegal kind code: retire with no effect
			end
		endcase
	end

	assign go = op_v_q && !post_q && !fl_act_q && !(|flush_req) &&
		(!need_wb || wb_cnt_q == '0) && (!need_quiet || all_quiet) &&
		(!need_space || wb_cnt_q != CW'(WB_DEPTH));

	// one request per cycle: flush, then forced drain, then op, then idle drain
	always_comb begin
		push_v = 1'b0;
		push_d = op_mem;
		wb_pop = 1'b0;
		fl_adv = 1'b0;
		op_done = 1'b0;
		if (fl_act_q) begin
			// combined data goes only to main memory
			push_d = '{cmd: MEM_WRITE, memory_only: 1'b1,
				addr: {wcb_line_q[fl_idx_q], fl_beat_q, SOWC_WORD_OFF'(0)},
				data: wcb_data_q[fl_idx_q][fl_beat_q], be: wcb_mask_q[fl_idx_q][fl_beat_q]};
			push_v = (push_d.be != '0);
			fl_adv = !push_v || buf_ready;
		end else if (wb_cnt_q != '0 && (need_wb || !(go && need_port))) begin
			push_d = wb_mem_q[wb_head_q]; // oldest first
			push_v = 1'b1;
			wb_pop = buf_ready;
		end else if (go && need_port) begin
			push_v = 1'b1;
			op_done = buf_ready;
		end
		if (go && !need_port) begin
			op_done = 1'b1;
		end
	end

	// op slot; a store never overtakes an older load since ops leave in order
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_v_q <= 1'b0;
			ready_q <= SOWC_READY_RST;
			op_q <= '0;
		end else begin
			if (op_valid && ready_q) begin
				op_q <= op_in;
				op_v_q <= 1'b1;
				ready_q <= 1'b0;
			end else if (op_done) begin
				op_v_q <= 1'b0;
				ready_q <= 1'b1;
			end
		end
	end

	// later ops wait until io, atomic or uncached requests have left
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			post_q <= 1'b0;
		end else if (op_done && need_quiet && need_port) begin
			post_q <= 1'b1;
		end else if (post_q && !mem_valid) begin
			post_q <= 1'b0;
		end
	end

	// fetch release pulse once a serializing event has drained
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_q <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			fetch_q <= op_done && (op_q.kind == OP_SERIALIZE || op_q.kind == OP_INTERRUPT);
			idle_q <= all_quiet && !op_v_q;
		end
	end

	// write buffer: push at tail, retire from head, strictly in order
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_head_q <= '0;
			wb_tail_q <= '0;
			wb_cnt_q <= '0;
		end else begin
			if (go && need_space) begin
				wb_mem_q[wb_tail_q] <= op_mem;
				wb_tail_q <= step(wb_tail_q);
			end
			if (wb_pop) begin
				wb_head_q <= step(wb_head_q);
			end
			if ((go && need_space) && !wb_pop) begin
				wb_cnt_q <= wb_cnt_q + CW'(1);
			end else if (wb_pop && !(go && need_space)) begin
				wb_cnt_q <= wb_cnt_q - CW'(1);
			end
		end
	end

	// flush engine walks each word of one buffer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fl_act_q <= 1'b0;
			fl_idx_q <= '0;
			fl_beat_q <= '0;
			victim_q <= '0;
		end else if (fl_act_q) begin
			if (fl_adv) begin
				fl_beat_q <= WCW'(fl_beat_q + 1'b1);
				if (fl_beat_q == WCW'(WCB_WORDS - 1)) begin
					fl_act_q <= 1'b0;
				end
			end
		end else if (op_v_q && !post_q && (|flush_req)) begin
			// lowest requested buffer first; round robin victim after eviction
			for (int i = WCB_NUM - 1; i >= 0; i--) begin
				if (flush_req[i]) begin
					fl_idx_q <= NIW'(i);
				end
			end
			fl_act_q <= 1'b1;
			fl_beat_q <= '0;
			if (is_comb) begin
				victim_q <= (victim_q == NIW'(WCB_NUM - 1)) ? '0 : NIW'(victim_q + 1'b1);
			end
		end
	end

	// combining buffers: assign range, merge bytes, clear after flush
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wcb_v_q <= '0;
			for (int i = 0; i < WCB_NUM; i++) begin
				wcb_line_q[i] <= '0;
				wcb_data_q[i] <= '0;
				wcb_mask_q[i] <= '0;
			end
		end else begin
			if (fl_act_q && fl_adv && fl_beat_q == WCW'(WCB_WORDS - 1)) begin
				wcb_v_q[fl_idx_q] <= 1'b0; // free for a new range
				wcb_mask_q[fl_idx_q] <= '0;
			end
			if (go && is_comb) begin
				if (any_hit) begin
					// later bytes replace earlier ones at the same address
					for (int b = 0; b < SOWC_BW; b++) begin
						if (op_q.be[b]) begin
							wcb_data_q[hit_idx][op_word][b*8 +: 8] <= op_q.data[b*8 +: 8];
							wcb_mask_q[hit_idx][op_word][b] <= 1'b1;
						end
					end
				end else begin
					// first write sets an aligned range the size of the buffer
					wcb_v_q[free_idx] <= 1'b1;
					wcb_line_q[free_idx] <= op_line;
					wcb_data_q[free_idx] <= '0;
					wcb_mask_q[free_idx] <= '0;
					wcb_data_q[free_idx][op_word] <= op_q.data;
					wcb_mask_q[free_idx][op_word] <= op_q.be;
				end
			end
		end
	end

	// request port buffer so a stalled memory side loses nothing
	sowc_buf2 #(
		.W($bits(sowc_mem_s))
	) u_out (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(push_v),
		.in_ready(buf_ready),
		.in_data(push_d),
		.out_valid(mem_valid),
		.out_ready(mem_ready),
		.out_data(mem_req)
	);

	assign op_ready = ready_q;
	assign fetch_release = fetch_q;
	assign idle = idle_q;
endmodule

/* sowc_unit_assertions.sv */
// port-level assertions for the ordering and combining unit
`timescale 1ns/1ps
module sowc_checker import sowc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic op_ready,
	input wire sowc_op_s op_in,
	input wire logic mem_valid,
	input wire logic mem_ready,
	input wire sowc_mem_s mem_req,
	input wire logic fetch_release,
	input wire logic idle
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// a request standing while memory refuses it
	sequence s_stall;
		mem_valid && !mem_ready;
	endsequence
	// an op taken from the pipeline
	sequence s_take;
		op_valid && op_ready;
	endsequence
	a_reset_state: assert property ($rose(rst_n) |-> op_ready && !mem_valid)
		else $error("slot or request wrong after reset");
	a_take_blocks: assert property (s_take |=> !op_ready)
		else $error("slot stayed free after a take");
	a_req_holds: assert property (s_stall |=> mem_valid && $stable(mem_req))
		else $error("request changed before memory took it");
	a_release_pulse: assert property (fetch_release |=> !fetch_release)
		else $error("fetch release longer than one cycle");
	a_release_drained: assert property (fetch_release |-> !mem_valid)
		else $error("fetch released with requests pending");
	a_idle_quiet: assert property (idle |-> !mem_valid)
		else $error("idle while a request stands");
	a_locked_cached: assert property (mem_valid && mem_req.cmd == MEM_LOCKED_RMW
		|-> !mem_req.memory_only)
		else $error("locked access kept from the caches");
	a_io_uncached: assert property (mem_valid && mem_req.cmd inside {MEM_IO_READ, MEM_IO_WRITE}
		|-> mem_req.memory_only)
		else $error("io access sent towards the caches");
	a_mask_live: assert property (mem_valid && mem_req.cmd == MEM_WRITE
		|-> mem_req.be != 8'h00)
		else $error("write with no byte enabled");
endmodule

bind sowc_unit sowc_checker sowc_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.op_valid(op_valid), .op_ready(op_ready), .op_in(op_in), .mem_valid(mem_valid),
	.mem_ready(mem_ready), .mem_req(mem_req), .fetch_release(fetch_release), .idle(idle));

/* store_ordering_write_combine_unit_test.sv */
// self-checking bench for the ordering and combining unit
`timescale 1ns/1ps
module store_ordering_write_combine_unit_test import sowc_pkg::*; ;
	localparam int SW = $bits(sowc_mem_s);
	localparam logic [31:0] LN = 32'h0000_2000; // one aligned combining line
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic op_valid = 1'b0;
	logic slow = 1'b0;
	logic nt_mark = 1'b0; // bypass marker for the next op offered
	sowc_op_s op_in = '0;
	logic op_ready, mem_valid, mem_ready, fetch_release, idle;
	sowc_mem_s mem_req;
	sowc_mem_s expq[$]; // expected requests, in order
	int bad_count = 0;
	int samples_checked = 0;
	int rel_n = 0; // fetch release pulses seen
	int rel_seen = 0; // requests taken when the last pulse came
	always #50 ref_clk = ~ref_clk;
	sowc_unit sowc_unit_i (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_ready(op_ready), .op_in(op_in), .mem_valid(mem_valid), .mem_ready(mem_ready),
		.mem_req(mem_req), .fetch_release(fetch_release), .idle(idle));
	sowc_mem_model sowc_mem_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
		.mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready));
	// counted at the falling edge so the log has settled
	always @(negedge ref_clk) begin
		if (fetch_release === 1'b1) begin
			rel_n++;
			rel_seen = sowc_mem_model_i.taken.size();
		end
	end
	task automatic check(input logic [SW-1:0] seen, input logic [SW-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hide fields a read does not define and bytes no enable covers
	function automatic sowc_mem_s msk(sowc_mem_s r);
		if (r.cmd inside {MEM_READ, MEM_IO_READ}) begin
			r.data = '0;
			r.be = '0;
		end
		if (r.cmd == MEM_READ)
			r.memory_only = 1'b0;
		for (int i = 0; i < SOWC_BW; i++)
			if (!r.be[i])
				r.data[i*8 +: 8] = 8'h00;
		return r;
	endfunction
	task automatic want(sowc_cmd_e c, logic mo, logic [31:0] a, logic [63:0] d, logic [7:0] b);
		expq.push_back('{c, mo, a, d, b});
	endtask
	// offer one op and hold it until the slot takes it
	task automatic send(sowc_op_e k, sowc_mtype_e t, logic [31:0] a, logic [63:0] d,
		logic [7:0] b);
		int n;
		n = 0;
		@(negedge ref_clk);
		op_in = '{k, t, nt_mark, a, d, b};
		op_valid = 1'b1;
		// ready only moves at the rising edge, so its level here decides the next take
		while (op_ready !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		op_valid = 1'b0;
		if (n >= 400)
			check(0, 1);
	endtask
	// wait for idle, then compare everything memory took
	task automatic settle();
		sowc_mem_s got;
		int n;
		n = 0;
		repeat (2) @(negedge ref_clk);
		while (idle !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 400)
			check(0, 1);
		check(SW'(sowc_mem_model_i.taken.size()), SW'(expq.size()));
		foreach (expq[i]) begin
			got = i < sowc_mem_model_i.taken.size() ? sowc_mem_model_i.taken[i] : '0;
			check(msk(got), msk(expq[i]));
		end
		expq = {};
		sowc_mem_model_i.taken = {};
	endtask
	task automatic t_fence();
		send(OP_LOAD, writeback_type, 32'h0000_0100, '0, 8'hFF);
		send(OP_LOAD_FENCE, writeback_type, '0, '0, 8'h00);
		send(OP_STORE, writeback_type, 32'h0000_0200, 64'hA5, 8'hFF);
		send(OP_FULL_FENCE, writeback_type, '0, '0, 8'h00);
		send(OP_LOAD, writeback_type, 32'h0000_0300, '0, 8'hFF);
		want(MEM_READ, 1'b0, 32'h0000_0100, '0, 8'h00);
		want(MEM_WRITE, 1'b0, 32'h0000_0200, 64'hA5, 8'hFF);
		want(MEM_READ, 1'b0, 32'h0000_0300, '0, 8'h00);
		settle();
	endtask
	// ordinary stores against a stalling memory keep program order
	task automatic t_order();
		sowc_mtype_e ty[3] = '{writeback_type, writethrough_type, write_protect_type};
		slow = 1'b1;
		for (int i = 0; i < 6; i++) begin
			send(OP_STORE, ty[i%3], 32'h0000_0400 + 32'(i*8), 64'(i), 8'hFF);
			want(MEM_WRITE, 1'b0, 32'h0000_0400 + 32'(i*8), 64'(i), 8'hFF);
		end
		// a load on a buffered word must not pass that store
		send(OP_LOAD, combining_type, 32'h0000_0428, '0, 8'hFF);
		want(MEM_READ, 1'b0, 32'h0000_0428, '0, 8'h00);
		settle();
		slow = 1'b0;
	endtask
	// bytes merge in range, later bytes win, empty words stay off the bus
	task automatic t_combine();
		send(OP_STORE, combining_type, LN + 32'h10, 64'h1111_1111_1111_1111, 8'h0F);
		send(OP_STORE, snooped_combining_type, LN + 32'h10, 64'h2222_2222_2222_2222, 8'h03);
		nt_mark = 1'b1;
		send(OP_STORE, writeback_type, LN, 64'h3333_3333_3333_3333, 8'hFF);
		nt_mark = 1'b0;
		send(OP_STORE_FENCE, writeback_type, '0, '0, 8'h00);
		want(MEM_WRITE, 1'b1, LN, 64'h3333_3333_3333_3333, 8'hFF);
		want(MEM_WRITE, 1'b1, LN + 32'h10, 64'h0000_0000_1111_2222, 8'h0F);
		settle();
		// a third line with both buffers taken evicts the oldest range first
		send(OP_STORE, combining_type, LN + 32'h40, 64'hA1, 8'h01);
		send(OP_STORE, combining_type, LN + 32'h60, 64'hB2, 8'h01);
		send(OP_STORE, combining_type, LN + 32'h80, 64'hC3, 8'h01);
		send(OP_STORE_FENCE, writeback_type, '0, '0, 8'h00);
		want(MEM_WRITE, 1'b1, LN + 32'h40, 64'hA1, 8'h01);
		want(MEM_WRITE, 1'b1, LN + 32'h80, 64'hC3, 8'h01);
		want(MEM_WRITE, 1'b1, LN + 32'h60, 64'hB2, 8'h01);
		settle();
	endtask
	// a plain store into the line, then an uncached load, each flush first
	task automatic t_flush();
		send(OP_STORE, combining_type, LN + 32'h8, 64'h44, 8'h01);
		send(OP_STORE, writeback_type, LN + 32'h8, 64'h55, 8'hFF);
		want(MEM_WRITE, 1'b1, LN + 32'h8, 64'h44, 8'h01);
		want(MEM_WRITE, 1'b0, LN + 32'h8, 64'h55, 8'hFF);
		settle();
		send(OP_STORE, combining_type, LN, 64'h66, 8'h01);
		send(OP_LOAD, uncached_type, 32'h0000_0800, '0, 8'hFF);
		want(MEM_WRITE, 1'b1, LN, 64'h66, 8'h01);
		want(MEM_READ, 1'b0, 32'h0000_0800, '0, 8'h00);
		settle();
	endtask
	// io and locked kinds flush combining data and are never buffered
	task automatic t_locked();
		sowc_op_e ks[4] = '{OP_IO_WRITE, OP_IO_READ, OP_ATOMIC, OP_SWAP};
		sowc_cmd_e cs[4] = '{MEM_IO_WRITE, MEM_IO_READ, MEM_LOCKED_RMW, MEM_LOCKED_RMW};
		for (int i = 0; i < 4; i++) begin
			send(OP_STORE, combining_type, LN, 64'h77, 8'h01);
			send(ks[i], writeback_type, 32'h0000_0040, 64'h5A, 8'hFF);
			want(MEM_WRITE, 1'b1, LN, 64'h77, 8'h01);
			want(cs[i], cs[i] != MEM_LOCKED_RMW, 32'h0000_0040, 64'h5A, 8'hFF);
			settle();
		end
	endtask
	// serializing kinds release the fetch only once all writes left
	task automatic t_release();
		sowc_op_e ks[2] = '{OP_SERIALIZE, OP_INTERRUPT};
		int r0;
		int n;
		slow = 1'b1;
		for (int i = 0; i < 2; i++) begin
			r0 = rel_n;
			n = 0;
			send(OP_STORE, writeback_type, 32'h0000_0600, 64'h88, 8'hFF);
			send(OP_STORE, combining_type, LN, 64'h99, 8'h01);
			send(ks[i], writeback_type, '0, '0, 8'h00);
			while (rel_n == r0 && n < 400) begin
				@(negedge ref_clk);
				n++;
			end
			check(SW'(rel_n), SW'(r0 + 1));
			check(SW'(rel_seen), SW'(2));
			want(MEM_WRITE, 1'b0, 32'h0000_0600, 64'h88, 8'hFF);
			want(MEM_WRITE, 1'b1, LN, 64'h99, 8'h01);
			settle();
		end
		slow = 1'b0;
	endtask
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#1000000;
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		t_fence();
		t_order();
		t_combine();
		t_flush();
		t_locked();
		t_release();
		wrap_up();
	end
endmodule
